// >>> pio_pkg.sv
// Package for the port I/O pin function block: register indices, reset values, modes.
// Assumes a plain byte-wide register port; each register sits at its own index.
package pio_pkg;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned ADDR_W = 4;
	// Register indices
	localparam logic [3:0] ADDR_P1_DIR = 4'h0;
	localparam logic [3:0] ADDR_P1_LATCH = 4'h1;
	localparam logic [3:0] ADDR_P3_DIR = 4'h2;
	localparam logic [3:0] ADDR_P3_LATCH = 4'h3;
	localparam logic [3:0] ADDR_PB_DIR = 4'h4;
	localparam logic [3:0] ADDR_PB_LATCH = 4'h5;
	localparam logic [3:0] ADDR_PULSE_EN = 4'h6;
	localparam logic [3:0] ADDR_MODE = 4'h7;
	// Reset values and fixed read-back values
	localparam logic [7:0] RST_ALL_ONE = 8'hFF;
	localparam logic [7:0] RST_ALL_ZERO = 8'h00;
	localparam logic [7:0] READ_WO = 8'hFF;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// Operating mode boundaries
	localparam logic [2:0] MODE_LAST_WIDE_DIR = 3'h4;
	localparam logic [2:0] MODE_LAST_EXPANDED = 3'h5;
	// Port B bit positions
	localparam int unsigned PB_TIMER_BIT = 3;
	localparam int unsigned PB_PULSE_LO = 4;
	typedef enum logic [1:0] {
		PIO_PIN_IN,
		PIO_PIN_GP_OUT,
		PIO_PIN_PULSE_OUT,
		PIO_PIN_TIMER_OUT
	} pio_pin_fn_t;
endpackage

// >>> pio_port_if.sv
// Interface carrying one port's latch, direction and pin levels between modules.
// Assumes the top drives the register side and the port slice drives the pin side.
`timescale 1ns/10ps
interface pio_port_if #(parameter int W = 8);
	logic [W-1:0] latch;
	logic [W-1:0] dir;
	logic [W-1:0] pin_in;
	logic [W-1:0] pin_out;
	logic [W-1:0] pin_oe_b;
	logic [W-1:0] readback;
	modport regs (output latch, dir, input readback);
	modport pins (input latch, dir, pin_in, output pin_out, pin_oe_b, readback);
endinterface

// >>> pio_port_slice.sv
// One port: drives pins from latch/direction and builds the read-back value.
// Assumes direction and latch come from flip-flops in the top module.
`timescale 1ns/10ps
module pio_port_slice #(
	parameter int W = 8
) (
	// Port bundle
	pio_port_if.pins port
);
	initial begin
		if (W < 1 || W > 8) begin
			$error("pio_port_slice: width out of range");
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			assign port.pin_out[i] = port.latch[i];
			assign port.pin_oe_b[i] = ~port.dir[i];
			// Output pins read back the latch, inputs the live level
			assign port.readback[i] = port.dir[i] ? port.latch[i] : port.pin_in[i];
		end
	endgenerate
endmodule

// >>> pio_top.sv
// Top of the port I/O pin function block: registers, modes, port B pin selection.
// Assumes single-cycle strobes, synchronous pins, and a mode input steady outside reset.
`timescale 1ns/10ps

// Functional notes
// - Port 1 direction resets to all ones in modes 1-4, zeros in 5-7.
// - Output pins keep driving through software standby; direction is retained.
// - Port 1 output pins are driven from the port 1 output latch.
// - Port 1 and 3 data reads return latch where direction is 1, pin level where 0; port B reads its latch.
// - Port 1 and 3 latches clear on reset or hardware standby only.
// - Port 3 direction is write-only and reads as all ones.
// - Modes 1-5 make port 3 the external data bus, ignoring direction.
// - Modes 6-7: port 3 pin outputs when direction 1, input when 0.
// - Port 3 direction clears on reset or hardware standby, kept in standby.
// - Port B pins 7-4: input, general output, or pulse-pattern output.
// - Port B pin 3 is timer compare output when level/select fields nonzero.
// - Port B pin 3 feeds the timer capture input when capture enabled.
module pio_top #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Chip state
	input wire logic [2:0] op_mode,
	input wire logic hw_standby,
	input wire logic sw_standby,
	// Register port
	input wire logic [pio_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [W-1:0] reg_rdata,
	// Port 1 pins
	input wire logic [W-1:0] p1_pin_in,
	output logic [W-1:0] p1_pin_out,
	output logic [W-1:0] p1_pin_oe_b,
	// Port 3 pins and external data bus
	input wire logic [W-1:0] p3_pin_in,
	output logic [W-1:0] p3_pin_out,
	output logic [W-1:0] p3_pin_oe_b,
	input wire logic [W-1:0] ext_bus_wdata,
	input wire logic ext_bus_drive,
	output logic [W-1:0] ext_bus_rdata,
	// Port B pins
	input wire logic [W-1:0] pb_pin_in,
	output logic [W-1:0] pb_pin_out,
	output logic [W-1:0] pb_pin_oe_b,
	// Pulse-pattern and timer 3
	input wire logic [3:0] pulse_pattern_out,
	input wire logic [1:0] timer3_output_level_select,
	input wire logic [1:0] timer3_compare_output_select,
	input wire logic capture_input_enable,
	input wire logic timer3_compare_out,
	output logic timer3_capture_in
);
	initial begin
		if (W != 8) begin
			$error("pio_top: ports are fixed at eight bits");
		end
	end

	logic [W-1:0] port1_direction_reg;
	logic [W-1:0] port1_output_latch_reg;
	logic [W-1:0] port3_direction_reg;
	logic [W-1:0] port3_output_latch_reg;
	logic [W-1:0] portb_direction_reg;
	logic [W-1:0] portb_output_latch_reg;
	logic [3:0] pulse_output_enable_reg_b;
	logic [W-1:0] reg_rdata_next;
	logic init_req;
	logic wide_dir_mode;
	logic expanded_mode;
	logic timer3_pin_claim;
	logic mode_loaded_reg;

	pio_port_if #(.W(W)) p1_if();
	pio_port_if #(.W(W)) p3_if();

	function automatic logic wr_hit(input logic [3:0] a);
		wr_hit = reg_wr && (reg_addr == a);
	endfunction

	// Hardware standby initialises like reset; software standby changes nothing
	assign init_req = hw_standby;
	assign wide_dir_mode = (op_mode != 3'h0) && (op_mode <= pio_pkg::MODE_LAST_WIDE_DIR);
	assign expanded_mode = (op_mode != 3'h0) && (op_mode <= pio_pkg::MODE_LAST_EXPANDED);

	// Port 1 direction: mode value lands on the first edge after reset and on hardware standby
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port1_direction_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (init_req) begin
			port1_direction_reg <= wide_dir_mode ? pio_pkg::RST_ALL_ONE : pio_pkg::RST_ALL_ZERO;
		end else if (wr_hit(pio_pkg::ADDR_P1_DIR)) begin
			port1_direction_reg <= reg_wdata;
		end else if (!mode_loaded_reg) begin
			// A write in the very first cycle wins; otherwise the mode value is stored here
			port1_direction_reg <= wide_dir_mode ? pio_pkg::RST_ALL_ONE : pio_pkg::RST_ALL_ZERO;
		end
	end

	// Async reset takes a constant; the mode value is applied on the first edge after release
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_loaded_reg <= 1'b0;
		end else begin
			mode_loaded_reg <= 1'b1;
		end
	end

	logic [W-1:0] port1_dir_eff;
	// Until the first edge the mode-dependent reset value is shown directly
	assign port1_dir_eff = mode_loaded_reg ? port1_direction_reg :
		(wide_dir_mode ? pio_pkg::RST_ALL_ONE : pio_pkg::RST_ALL_ZERO);

	logic first_edge_reg;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			first_edge_reg <= 1'b0;
		end else begin
			first_edge_reg <= mode_loaded_reg;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port1_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (init_req) begin
			port1_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (wr_hit(pio_pkg::ADDR_P1_LATCH)) begin
			port1_output_latch_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port3_direction_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (init_req) begin
			port3_direction_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (wr_hit(pio_pkg::ADDR_P3_DIR)) begin
			port3_direction_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			port3_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (init_req) begin
			port3_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
		end else if (wr_hit(pio_pkg::ADDR_P3_LATCH)) begin
			port3_output_latch_reg <= reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			portb_direction_reg <= pio_pkg::RST_ALL_ZERO;
			portb_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
			pulse_output_enable_reg_b <= 4'h0;
		end else if (init_req) begin
			portb_direction_reg <= pio_pkg::RST_ALL_ZERO;
			portb_output_latch_reg <= pio_pkg::RST_ALL_ZERO;
			pulse_output_enable_reg_b <= 4'h0;
		end else begin
			if (wr_hit(pio_pkg::ADDR_PB_DIR)) begin
				portb_direction_reg <= reg_wdata;
			end
			if (wr_hit(pio_pkg::ADDR_PB_LATCH)) begin
				portb_output_latch_reg <= reg_wdata;
			end
			if (wr_hit(pio_pkg::ADDR_PULSE_EN)) begin
				pulse_output_enable_reg_b <= reg_wdata[3:0];
			end
		end
	end

	// Port slices
	assign p1_if.latch = port1_output_latch_reg;
	assign p1_if.dir = port1_dir_eff;
	assign p1_if.pin_in = p1_pin_in;
	assign p3_if.latch = port3_output_latch_reg;
	assign p3_if.dir = port3_direction_reg;
	assign p3_if.pin_in = p3_pin_in;

	pio_port_slice #(.W(W)) u_p1 (
		.port(p1_if.pins)
	);
	pio_port_slice #(.W(W)) u_p3 (
		.port(p3_if.pins)
	);

	assign p1_pin_out = p1_if.pin_out;
	assign p1_pin_oe_b = p1_if.pin_oe_b;

	// Expanded modes hand port 3 to the data bus; direction register is ignored
	assign p3_pin_out = expanded_mode ? ext_bus_wdata : p3_if.pin_out;
	assign p3_pin_oe_b = expanded_mode ? {W{~ext_bus_drive}} : p3_if.pin_oe_b;
	assign ext_bus_rdata = expanded_mode ? p3_pin_in : pio_pkg::RST_ALL_ZERO;

	// Port B pin function selection
	assign timer3_pin_claim = (timer3_output_level_select != 2'h0) || (timer3_compare_output_select != 2'h0);

	function automatic pio_pkg::pio_pin_fn_t pb_fn(input logic dir, input logic pen);
		if (!dir) begin
			pb_fn = pio_pkg::PIO_PIN_IN;
		end else if (pen) begin
			pb_fn = pio_pkg::PIO_PIN_PULSE_OUT;
		end else begin
			pb_fn = pio_pkg::PIO_PIN_GP_OUT;
		end
	endfunction

	genvar k;
	generate
		for (k = 0; k < W; k++) begin : g_pb
			pio_pkg::pio_pin_fn_t fn;
			if (k >= pio_pkg::PB_PULSE_LO) begin : g_pulse
				assign fn = pb_fn(portb_direction_reg[k], pulse_output_enable_reg_b[k - pio_pkg::PB_PULSE_LO]);
			end else if (k == pio_pkg::PB_TIMER_BIT) begin : g_timer
				// Timer claim beats direction; pin 3 has no pulse enable
				assign fn = timer3_pin_claim ? pio_pkg::PIO_PIN_TIMER_OUT : pb_fn(portb_direction_reg[k], 1'b0);
			end else begin : g_plain
				assign fn = pb_fn(portb_direction_reg[k], 1'b0);
			end
			always_comb begin
				unique case (fn)
					pio_pkg::PIO_PIN_IN: begin
						pb_pin_out[k] = portb_output_latch_reg[k];
						pb_pin_oe_b[k] = 1'b1;
					end
					pio_pkg::PIO_PIN_GP_OUT: begin
						pb_pin_out[k] = portb_output_latch_reg[k];
						pb_pin_oe_b[k] = 1'b0;
					end
					pio_pkg::PIO_PIN_PULSE_OUT: begin
						pb_pin_out[k] = (k >= pio_pkg::PB_PULSE_LO) ? pulse_pattern_out[k % 4] : 1'b0;
						pb_pin_oe_b[k] = 1'b0;
					end
					pio_pkg::PIO_PIN_TIMER_OUT: begin
						pb_pin_out[k] = timer3_compare_out;
						pb_pin_oe_b[k] = 1'b0;
					end
				endcase
			end
		end
	endgenerate

	assign timer3_capture_in = capture_input_enable & pb_pin_in[pio_pkg::PB_TIMER_BIT];

	// Read data, one cycle after the strobe
	always_comb begin
		reg_rdata_next = pio_pkg::READ_UNMAPPED;
		unique case (reg_addr)
			pio_pkg::ADDR_P1_DIR: reg_rdata_next = port1_dir_eff;
			pio_pkg::ADDR_P1_LATCH: reg_rdata_next = p1_if.readback;
			pio_pkg::ADDR_P3_DIR: reg_rdata_next = pio_pkg::READ_WO;
			pio_pkg::ADDR_P3_LATCH: reg_rdata_next = p3_if.readback;
			pio_pkg::ADDR_PB_DIR: reg_rdata_next = portb_direction_reg;
			pio_pkg::ADDR_PB_LATCH: reg_rdata_next = portb_output_latch_reg;
			pio_pkg::ADDR_PULSE_EN: reg_rdata_next = {4'h0, pulse_output_enable_reg_b};
			pio_pkg::ADDR_MODE: reg_rdata_next = {5'h00, op_mode};
			default: reg_rdata_next = pio_pkg::READ_UNMAPPED;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= pio_pkg::RST_ALL_ZERO;
		end else if (reg_rd) begin
			reg_rdata <= reg_rdata_next;
		end else begin
			reg_rdata <= pio_pkg::RST_ALL_ZERO;
		end
	end

	// Assertions
	AST_P1_DIR_INIT: assert property (@(posedge clk) disable iff (!rst_b)
		hw_standby |=> port1_direction_reg == ($past(wide_dir_mode) ? 8'hFF : 8'h00))
		else $error("port 1 direction init value wrong");
	AST_SW_STANDBY_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		(sw_standby && !hw_standby && !reg_wr) |=> $stable(p1_pin_oe_b) && $stable(port3_direction_reg))
		else $error("standby lost pin state");
	AST_P1_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
		p1_pin_out == port1_output_latch_reg)
		else $error("port 1 pin not from latch");
	AST_P3_READBACK: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_rd && reg_addr == pio_pkg::ADDR_P3_LATCH) |=>
		reg_rdata == (($past(port3_direction_reg) & $past(port3_output_latch_reg)) |
		(~$past(port3_direction_reg) & $past(p3_pin_in))))
		else $error("port 3 readback mux wrong");
	AST_LATCH_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		hw_standby |=> port1_output_latch_reg == 8'h00 && port3_output_latch_reg == 8'h00)
		else $error("latch not cleared");
	AST_P3_DIR_READ: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_rd && reg_addr == pio_pkg::ADDR_P3_DIR) |=> reg_rdata == 8'hFF)
		else $error("write-only read not ones");
	AST_P3_BUS: assert property (@(posedge clk) disable iff (!rst_b)
		expanded_mode |-> p3_pin_out == ext_bus_wdata)
		else $error("port 3 not data bus");
	AST_P3_SINGLE: assert property (@(posedge clk) disable iff (!rst_b)
		!expanded_mode |-> p3_pin_oe_b == ~port3_direction_reg)
		else $error("port 3 direction ignored");
	AST_P3_DIR_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		hw_standby |=> port3_direction_reg == 8'h00)
		else $error("port 3 direction not cleared");
	AST_PB_PULSE: assert property (@(posedge clk) disable iff (!rst_b)
		(portb_direction_reg[7] && pulse_output_enable_reg_b[3]) |-> !pb_pin_oe_b[7] && pb_pin_out[7] == pulse_pattern_out[3])
		else $error("pulse output not selected");
	AST_PB_TIMER: assert property (@(posedge clk) disable iff (!rst_b)
		timer3_pin_claim |-> !pb_pin_oe_b[3] && pb_pin_out[3] == timer3_compare_out)
		else $error("timer output not selected");
	AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_b)
		capture_input_enable |-> timer3_capture_in == pb_pin_in[3])
		else $error("capture input not fed");
	AST_WRITE_TIMING: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_wr && reg_addr == pio_pkg::ADDR_P1_LATCH && !hw_standby) |=> p1_pin_out == $past(reg_wdata))
		else $error("write did not reach pins");
	AST_P1_DIR_FIRST: assert property (@(posedge clk) disable iff (!rst_b)
		($rose(mode_loaded_reg) && !$past(reg_wr)) |-> port1_direction_reg == (wide_dir_mode ? 8'hFF : 8'h00))
		else $error("port 1 direction not set from mode after reset");
	AST_P1_READBACK: assert property (@(posedge clk) disable iff (!rst_b)
		(reg_rd && reg_addr == pio_pkg::ADDR_P1_LATCH) |=>
		reg_rdata == (($past(port1_dir_eff) & $past(port1_output_latch_reg)) |
		(~$past(port1_dir_eff) & $past(p1_pin_in))))
		else $error("port 1 readback mux wrong");
	AST_PB_GP_OUT: assert property (@(posedge clk) disable iff (!rst_b)
		(portb_direction_reg[6] && !pulse_output_enable_reg_b[2]) |-> !pb_pin_oe_b[6] && pb_pin_out[6] == portb_output_latch_reg[6])
		else $error("general output not selected");
	AST_PB3_INPUT: assert property (@(posedge clk) disable iff (!rst_b)
		(!timer3_pin_claim && !portb_direction_reg[3]) |-> pb_pin_oe_b[3])
		else $error("port B pin 3 driven while input");
	AST_EXT_BUS_READ: assert property (@(posedge clk) disable iff (!rst_b)
		expanded_mode |-> ext_bus_rdata == p3_pin_in)
		else $error("data bus read not from port 3 pins");

	COV_P3_WRITE_READ: cover property (@(posedge clk) disable iff (!rst_b)
		reg_wr && reg_addr == pio_pkg::ADDR_P3_LATCH ##1 reg_rd && reg_addr == pio_pkg::ADDR_P3_LATCH);
	COV_TIMER_CLAIM: cover property (@(posedge clk) disable iff (!rst_b) timer3_pin_claim && portb_direction_reg[3]);
	COV_HW_STANDBY: cover property (@(posedge clk) disable iff (!rst_b) hw_standby ##1 !hw_standby);
	COV_EXPANDED: cover property (@(posedge clk) disable iff (!rst_b) expanded_mode && ext_bus_drive);
	COV_SW_STANDBY: cover property (@(posedge clk) disable iff (!rst_b) sw_standby && first_edge_reg);
endmodule

// >>> pio_pin_model.sv
// Board-side model of one port's pins: resolves each pin from device drive and board level.
// Assumes the device drives a pin while its active-low output enable is low.
`timescale 1ns/10ps
module pio_pin_model #(
	parameter int W = 8
) (
	// Device side
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] pin_oe_b,
	// Board side
	input wire logic [W-1:0] board_level,
	output logic [W-1:0] pin_in
);
	// A released pin shows the board level, never the last value the device drove
	always_comb begin
		for (int i = 0; i < W; i++) begin
			pin_in[i] = pin_oe_b[i] ? board_level[i] : pin_out[i];
		end
	end
endmodule

// >>> pio_tb_top.sv
// Self-checking bench for the port I/O block: register tasks, mode resets, pin checks.
// Assumes the pio_pkg register map and the pin model for ports 1, 3 and B.
`timescale 1ns/10ps
module pio_tb_top;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [2:0] op_mode = 3'h6;
	logic hw_standby = 1'b0;
	logic sw_standby = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_rdata, bus_rdata;
	logic [7:0] p1_in, p1_out, p1_oe_b, p3_in, p3_out, p3_oe_b, pb_in, pb_out, pb_oe_b;
	logic [7:0] lvl1 = 8'h3C;
	logic [7:0] lvl3 = 8'h99;
	logic [7:0] lvlb = 8'h00;
	logic [7:0] bus_wdata = 8'h00;
	logic bus_drive = 1'b0;
	logic [3:0] pulse = 4'h0;
	logic [1:0] ols = 2'h0;
	logic [1:0] cos = 2'h0;
	logic cap_en = 1'b0;
	logic cmp_out = 1'b0;
	logic cap_in;
	int failures = 0;
	int cmp_count = 0;
	int cycles = 0;

	always #4 clk = ~clk;

	pio_top #(.W(8)) pio_top_inst (.clk(clk), .rst_b(rst_b), .op_mode(op_mode), .hw_standby(hw_standby),
		.sw_standby(sw_standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .p1_pin_in(p1_in), .p1_pin_out(p1_out), .p1_pin_oe_b(p1_oe_b),
		.p3_pin_in(p3_in), .p3_pin_out(p3_out), .p3_pin_oe_b(p3_oe_b), .ext_bus_wdata(bus_wdata),
		.ext_bus_drive(bus_drive), .ext_bus_rdata(bus_rdata), .pb_pin_in(pb_in), .pb_pin_out(pb_out),
		.pb_pin_oe_b(pb_oe_b), .pulse_pattern_out(pulse), .timer3_output_level_select(ols),
		.timer3_compare_output_select(cos), .capture_input_enable(cap_en), .timer3_compare_out(cmp_out),
		.timer3_capture_in(cap_in));

	// One model per port: index 0 is port 1, 1 is port 3, 2 is port B
	pio_pin_model #(.W(8)) pio_pin_model_inst [2:0] (.pin_out({pb_out, p3_out, p1_out}),
		.pin_oe_b({pb_oe_b, p3_oe_b, p1_oe_b}), .board_level({lvlb, lvl3, lvl1}), .pin_in({pb_in, p3_in, p1_in}));

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic settle();
		@(posedge clk);
		#1;
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		#1;
	endtask

	// Read data stands only in the cycle after the strobe, so it is taken just after that edge
	task automatic rdchk(input logic [3:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(name, exp, reg_rdata);
	endtask

	task automatic hwsb();
		@(posedge clk);
		hw_standby <= 1'b1;
		@(posedge clk);
		hw_standby <= 1'b0;
		#1;
	endtask

	task automatic restart(input logic [2:0] m);
		@(posedge clk);
		rst_b <= 1'b0;
		op_mode <= m;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		settle();
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			failures++;
			results();
		end
	end

	initial begin
		restart(3'h6);
		rdchk(pio_pkg::ADDR_P1_DIR, 8'h00, "p1 dir reset");
		chk("p1 oe_b reset", 8'hFF, p1_oe_b);
		wr(pio_pkg::ADDR_P1_DIR, 8'hFF);
		rdchk(pio_pkg::ADDR_P1_LATCH, 8'h00, "p1 latch reset");
		wr(pio_pkg::ADDR_P1_LATCH, 8'hA5);
		chk("p1 out", 8'hA5, p1_out);
		wr(pio_pkg::ADDR_P1_DIR, 8'h0F);
		chk("p1 oe_b", 8'hF0, p1_oe_b);
		rdchk(pio_pkg::ADDR_P1_LATCH, 8'h35, "p1 mixed read");
		$display("test port1 done");
		wr(pio_pkg::ADDR_P3_DIR, 8'hF0);
		chk("p3 oe_b", 8'h0F, p3_oe_b);
		rdchk(pio_pkg::ADDR_P3_LATCH, 8'h09, "p3 latch reset");
		wr(pio_pkg::ADDR_P3_LATCH, 8'h5A);
		chk("p3 out", 8'h5A, p3_out);
		rdchk(pio_pkg::ADDR_P3_LATCH, 8'h59, "p3 mixed read");
		rdchk(pio_pkg::ADDR_P3_DIR, 8'hFF, "p3 dir read");
		rdchk(4'hC, 8'h00, "unmapped read");
		$display("test port3 done");
		@(posedge clk);
		sw_standby <= 1'b1;
		repeat (4) settle();
		chk("p1 out standby", 8'hA5, p1_out);
		chk("p1 oe_b standby", 8'hF0, p1_oe_b);
		chk("p3 oe_b standby", 8'h0F, p3_oe_b);
		@(posedge clk);
		sw_standby <= 1'b0;
		hwsb();
		chk("p3 oe_b hw standby", 8'hFF, p3_oe_b);
		chk("p1 oe_b hw standby", 8'hFF, p1_oe_b);
		wr(pio_pkg::ADDR_P3_DIR, 8'hFF);
		chk("p3 out cleared", 8'h00, p3_out);
		wr(pio_pkg::ADDR_P1_DIR, 8'hFF);
		chk("p1 out cleared", 8'h00, p1_out);
		$display("test standby done");
		restart(3'h2);
		chk("p1 oe_b mode 2", 8'h00, p1_oe_b);
		rdchk(pio_pkg::ADDR_P1_DIR, 8'hFF, "p1 dir mode 2");
		wr(pio_pkg::ADDR_P1_DIR, 8'h00);
		chk("p1 oe_b written", 8'hFF, p1_oe_b);
		hwsb();
		chk("p1 oe_b hw standby mode 2", 8'h00, p1_oe_b);
		wr(pio_pkg::ADDR_P3_DIR, 8'h0F);
		@(posedge clk);
		bus_wdata <= 8'hC3;
		bus_drive <= 1'b1;
		settle();
		chk("p3 bus out", 8'hC3, p3_out);
		chk("p3 bus oe_b", 8'h00, p3_oe_b);
		@(posedge clk);
		bus_drive <= 1'b0;
		settle();
		chk("p3 bus released", 8'hFF, p3_oe_b);
		chk("bus read", 8'h99, bus_rdata);
		$display("test expanded done");
		restart(3'h5);
		chk("p1 oe_b mode 5", 8'hFF, p1_oe_b);
		chk("p3 out mode 5", 8'hC3, p3_out);
		chk("bus read mode 5", 8'h99, bus_rdata);
		$display("test mode 5 done");
		restart(3'h7);
		wr(pio_pkg::ADDR_PB_LATCH, 8'h40);
		wr(pio_pkg::ADDR_PULSE_EN, 8'h0A);
		@(posedge clk);
		pulse <= 4'h9;
		wr(pio_pkg::ADDR_PB_DIR, 8'hC0);
		chk("pb oe_b", 8'h3F, pb_oe_b);
		chk("pb out", 8'hC0, pb_out & 8'hC0);
		@(posedge clk);
		pulse <= 4'h6;
		settle();
		chk("pb out pulse", 8'h40, pb_out & 8'hC0);
		// Every nonzero select code must hand PB3 to the timer, even with its direction at input
		for (int i = 1; i < 16; i++) begin
			@(posedge clk);
			{ols, cos} <= i[3:0];
			cmp_out <= i[0];
			settle();
			chk("pb3 timer", {6'h00, 1'b0, i[0]}, {6'h00, pb_oe_b[3], pb_out[3]});
		end
		@(posedge clk);
		{ols, cos} <= 4'h0;
		cap_en <= 1'b1;
		lvlb <= 8'h08;
		settle();
		chk("pb3 released", 8'h01, {7'h00, pb_oe_b[3]});
		chk("capture in", 8'h01, {7'h00, cap_in});
		@(posedge clk);
		cap_en <= 1'b0;
		settle();
		chk("capture off", 8'h00, {7'h00, cap_in});
		$display("test port b done");
		results();
	end
endmodule
